/* File: core/pisr_core.v */
// PHY interrupt flags, link control bits, page/port selection and per-port status page
//
// Function
// R1 - State timeout sets sticky timeout flag; hardware reset or write-one clears it.
// R2 - Each state timeout also requests a bus reset.
// R3 - Timeout flag plus resume enable with inactive link drives link wake.
// R4 - Connect, bias, disable or fault change on enabled port sets port-event flag.
// R5 - With resume enable set, any port resume start sets port-event flag.
// R6 - Fast arbitration enable gates accelerated arbitration; zero at reset, survives bus reset.
// R7 - Software sets fast arbitration only with an enhanced link controller.
// R8 - Mixed speed concatenation enable; zero at reset, survives bus reset.
// R9 - Three-bit page field selects page at addresses 8 to 15.
// R10 - Four-bit port field selects port for per-port status, from zero.
// R11 - Page zero plus port number maps that port's status into upper addresses.
// R12 - Unimplemented selected port makes every status page register read zero.
// R13 - Status page layout: line states, child, attach, bias, off; speed, enable, fault.
// R14 - Line A state reports arbitration value: 11 Z, 01 one, 10 zero, 00 invalid.
// R15 - Line B state reports its pair with the same coding.
// R16 - Downstream flag one for child; disconnected, disabled, suspended ports read child.
// R17 - Downstream flag is meaningless after bus reset until tree identification ends.
// R18 - Attach flag sets only after connection stable about 341 ms; survives bus reset.
// R19 - Resume enable lets port resume starts set port-event flag; zero at reset.
// R20 - Link active only when power status input and link active bit are set.
// R21 - Port event enable per port gates its events; zero at reset.
// R22 - Writing zero leaves flags; hardware set beats a simultaneous clearing write.

`include "pisr_regs.vh"

`default_nettype none

module pisr_core #(
  parameter [`PISR_DBW-1:0] DEBOUNCE_CYC = `PISR_DEBOUNCE_CYC
) (
  // Clock, reset, enable
  input  wire                            clk,
  input  wire                            rst_n,
  input  wire                            ce,
  // Register port
  input  wire [`PISR_AW-1:0]             addr,
  input  wire [`PISR_DW-1:0]             wdata,
  input  wire                            wr,
  input  wire                            rd,
  output reg  [`PISR_DW-1:0]             rdata,
  // Arbitration core events
  input  wire                            state_timeout,
  output reg                             bus_reset_req,
  // Link side
  input  wire                            link_power_status,
  output wire                            link_wake_output,
  output wire                            fast_arbitration_enable,
  output wire                            mixed_speed_concat_enable,
  // Per-port line and state inputs
  input  wire [2*`PISR_NPORTS-1:0]       line_a_state,
  input  wire [2*`PISR_NPORTS-1:0]       line_b_state,
  input  wire [`PISR_NPORTS-1:0]         port_child,
  input  wire [`PISR_NPORTS-1:0]         port_suspended,
  input  wire [`PISR_NPORTS-1:0]         conn_raw,
  input  wire [`PISR_NPORTS-1:0]         bias_debounced,
  input  wire [3*`PISR_NPORTS-1:0]       peer_speed,
  input  wire [`PISR_NPORTS-1:0]         resume_start,
  input  wire [`PISR_NPORTS-1:0]         fault_event,
  // Per-port control outputs
  output wire [`PISR_NPORTS-1:0]         port_disabled
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // True when a port index names an implemented port
  function port_ok;
    input [3:0] idx;
    begin
      port_ok = (idx < `PISR_NPORTS);
    end
  endfunction

  // True when a strobe hits the given register offset
  function reg_hit;
    input                strobe;
    input [`PISR_AW-1:0] a;
    input [`PISR_AW-1:0] ofs;
    begin
      reg_hit = strobe && (a == ofs);
    end
  endfunction

  // Two-bit field of the selected port
  function [1:0] pick2;
    input [2*`PISR_NPORTS-1:0] vec;
    input [1:0]                idx;
    begin
      pick2 = vec[2*idx +: 2];
    end
  endfunction

  // Three-bit field of the selected port
  function [2:0] pick3;
    input [3*`PISR_NPORTS-1:0] vec;
    input [1:0]                idx;
    begin
      pick3 = vec[3*idx +: 3];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Control state

  reg                      link_active_control_q;
  reg                      resume_event_enable_q;
  reg                      state_timeout_flag_q;
  reg                      pei_q;
  reg                      fastarb_q;
  reg                      mixspd_q;
  reg [2:0]                page_q;
  reg [3:0]                port_q;
  reg [`PISR_NPORTS-1:0]   dis_q;
  reg [`PISR_NPORTS-1:0]   pie_q;
  reg [`PISR_NPORTS-1:0]   fault_q;
  reg [`PISR_NPORTS-1:0]   con_q;
  reg [`PISR_NPORTS-1:0]   con_prev_q;
  reg [`PISR_NPORTS-1:0]   bias_prev_q;
  reg [`PISR_NPORTS-1:0]   dis_prev_q;
  reg [`PISR_NPORTS-1:0]   fault_prev_q;

  wire                     wr_linkctl;
  wire                     wr_pageport;
  wire                     status_page;
  wire [1:0]               sel;
  wire                     wr_pstat0;
  wire                     wr_pstat1;
  wire [`PISR_NPORTS-1:0]  port_evt;
  wire                     link_active;

  assign wr_linkctl  = reg_hit(wr, addr, `PISR_OFS_LINKCTL);
  assign wr_pageport = reg_hit(wr, addr, `PISR_OFS_PAGEPORT);
  // R11 page zero selects port status
  assign status_page = (page_q == `PISR_PAGE_STATUS) && port_ok(port_q);
  assign sel         = port_q[1:0];
  assign wr_pstat0   = status_page && reg_hit(wr, addr, `PISR_OFS_PSTAT0);
  assign wr_pstat1   = status_page && reg_hit(wr, addr, `PISR_OFS_PSTAT1);

  ////////////////////////////////////////////////////////////////////////////////
  // Per-port debounce, control bits and event detection

  genvar g;
  generate
    for (g = 0; g < `PISR_NPORTS; g = g + 1) begin : g_port
      reg [`PISR_DBW-1:0] cnt_q;
      wire                sel_me;
      wire                con_chg;
      wire                bias_chg;
      wire                dis_chg;
      wire                fault_chg;
      assign sel_me = (sel == g);

      // R18 attach debounce
      always @(posedge clk) begin
        if (!rst_n) begin
          cnt_q    <= {`PISR_DBW{1'b0}};
          con_q[g] <= 1'b0;
        end else if (ce) begin
          if (!conn_raw[g]) begin
            cnt_q    <= {`PISR_DBW{1'b0}};
            con_q[g] <= 1'b0;
          end else if (cnt_q >= DEBOUNCE_CYC - 1'b1) begin
            // Counter parks here, so a long connection never wraps
            con_q[g] <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      end

      // R21 port enable and disable control
      always @(posedge clk) begin
        if (!rst_n) begin
          dis_q[g] <= 1'b0;
          pie_q[g] <= 1'b0;
        end else if (ce) begin
          if (wr_pstat0 && sel_me) begin
            dis_q[g] <= wdata[`PISR_BIT_DIS];
          end
          if (wr_pstat1 && sel_me) begin
            pie_q[g] <= wdata[`PISR_BIT_PIE];
          end
        end
      end

      // R22 fault set wins over clear
      always @(posedge clk) begin
        if (!rst_n) begin
          fault_q[g] <= 1'b0;
        end else if (ce) begin
          if (fault_event[g]) begin
            fault_q[g] <= 1'b1;
          end else if (wr_pstat1 && sel_me && wdata[`PISR_BIT_FAULT]) begin
            fault_q[g] <= 1'b0;
          end
        end
      end

      // Previous values for change detection
      always @(posedge clk) begin
        if (!rst_n) begin
          con_prev_q[g]   <= 1'b0;
          bias_prev_q[g]  <= 1'b0;
          dis_prev_q[g]   <= 1'b0;
          fault_prev_q[g] <= 1'b0;
        end else if (ce) begin
          con_prev_q[g]   <= con_q[g];
          bias_prev_q[g]  <= bias_debounced[g];
          dis_prev_q[g]   <= dis_q[g];
          fault_prev_q[g] <= fault_q[g];
        end
      end

      // Registered bits compare with their last value, bias with the pin itself
      assign con_chg   = con_q[g] ^ con_prev_q[g];
      assign bias_chg  = bias_debounced[g] ^ bias_prev_q[g];
      assign dis_chg   = dis_q[g] ^ dis_prev_q[g];
      assign fault_chg = fault_q[g] ^ fault_prev_q[g];

      // R4 status change on enabled port
      assign port_evt[g] = pie_q[g] && (con_chg || bias_chg || dis_chg || fault_chg);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Global control and flags
  // None of these react to bus reset: only rst_n touches them.

  always @(posedge clk) begin
    if (!rst_n) begin
      link_active_control_q   <= `PISR_RST_LINK_ACTIVE_CONTROL;
      resume_event_enable_q    <= 1'b0;
      fastarb_q <= 1'b0;
      mixspd_q  <= 1'b0;
    end else if (ce) begin
      if (wr_linkctl) begin
        link_active_control_q   <= wdata[`PISR_BIT_LINK_ACTIVE_CONTROL];
        // R19 resume enable
        resume_event_enable_q    <= wdata[`PISR_BIT_RESUME_EVENT_ENABLE];
        // R6 fast arbitration
        fastarb_q <= wdata[`PISR_BIT_FASTARB];
        // R8 mixed speed
        mixspd_q  <= wdata[`PISR_BIT_MIXSPD];
      end
    end
  end

  // Page and port selection
  always @(posedge clk) begin
    if (!rst_n) begin
      page_q <= 3'h0;
      port_q <= 4'h0;
    end else if (ce) begin
      if (wr_pageport) begin
        // R9 page select
        page_q <= wdata[`PISR_PAGE_HI:`PISR_PAGE_LO];
        // R10 port select
        port_q <= wdata[`PISR_PORT_HI:`PISR_PORT_LO];
      end
    end
  end

  // R1 state timeout flag
  always @(posedge clk) begin
    if (!rst_n) begin
      state_timeout_flag_q <= 1'b0;
    end else if (ce) begin
      // R22 set beats clear
      if (state_timeout) begin
        state_timeout_flag_q <= 1'b1;
      end else if (wr_linkctl && wdata[`PISR_BIT_STATE_TIMEOUT_FLAG]) begin
        state_timeout_flag_q <= 1'b0;
      end
    end
  end

  // R4 port event flag
  always @(posedge clk) begin
    if (!rst_n) begin
      pei_q <= 1'b0;
    end else if (ce) begin
      // R5 resume start
      if ((|port_evt) || (resume_event_enable_q && (|resume_start))) begin
        pei_q <= 1'b1;
      end else if (wr_linkctl && wdata[`PISR_BIT_PEI]) begin
        pei_q <= 1'b0;
      end
    end
  end

  // One pulse per timeout; the arbitration core runs the reset sequence itself
  // R2 timeout requests bus reset
  always @(posedge clk) begin
    if (!rst_n) begin
      bus_reset_req <= 1'b0;
    end else if (ce) begin
      bus_reset_req <= state_timeout;
    end
  end

  // R20 link activity
  assign link_active = link_power_status && link_active_control_q;
  // R3 wake inactive link
  assign link_wake_output = state_timeout_flag_q && resume_event_enable_q && !link_active;

  // R6 fast arbitration gate
  assign fast_arbitration_enable   = fastarb_q;
  assign mixed_speed_concat_enable = mixspd_q;
  assign port_disabled             = dis_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Read path
  // Read data stand only in the cycle after the strobe, zero otherwise.

  reg  [`PISR_DW-1:0] rd_d;
  wire [1:0]          la;
  wire [1:0]          lb;
  wire                ch;

  // R14 line A state
  assign la = pick2(line_a_state, sel);
  // R15 line B state
  assign lb = pick2(line_b_state, sel);
  // R16 detached ports read child
  assign ch = port_child[sel] | !con_q[sel] | dis_q[sel] | port_suspended[sel];

  always @* begin
    rd_d = {`PISR_DW{1'b0}};
    case (addr)
      `PISR_OFS_LINKCTL: begin
        rd_d[`PISR_BIT_LINK_ACTIVE_CONTROL]   = link_active_control_q;
        rd_d[`PISR_BIT_RESUME_EVENT_ENABLE]    = resume_event_enable_q;
        rd_d[`PISR_BIT_STATE_TIMEOUT_FLAG]    = state_timeout_flag_q;
        rd_d[`PISR_BIT_PEI]     = pei_q;
        rd_d[`PISR_BIT_FASTARB] = fastarb_q;
        rd_d[`PISR_BIT_MIXSPD]  = mixspd_q;
      end
      `PISR_OFS_PAGEPORT: begin
        rd_d[`PISR_PAGE_HI:`PISR_PAGE_LO] = page_q;
        rd_d[`PISR_PORT_HI:`PISR_PORT_LO] = port_q;
      end
      // R12 absent port reads zero
      `PISR_OFS_PSTAT0: begin
        if (status_page) begin
          // R13 first status register
          rd_d[`PISR_LA_HI:`PISR_LA_LO] = la;
          rd_d[`PISR_LB_HI:`PISR_LB_LO] = lb;
          // R17 child raw until tree id
          rd_d[`PISR_BIT_CH]   = ch;
          rd_d[`PISR_BIT_CON]  = con_q[sel];
          rd_d[`PISR_BIT_BIAS] = bias_debounced[sel];
          rd_d[`PISR_BIT_DIS]  = dis_q[sel];
        end
      end
      `PISR_OFS_PSTAT1: begin
        if (status_page) begin
          // R13 second status register
          rd_d[`PISR_SPD_HI:`PISR_SPD_LO] = pick3(peer_speed, sel);
          rd_d[`PISR_BIT_PIE]   = pie_q[sel];
          rd_d[`PISR_BIT_FAULT] = fault_q[sel];
        end
      end
      default: begin
        rd_d = {`PISR_DW{1'b0}};
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      rdata <= {`PISR_DW{1'b0}};
    end else if (ce) begin
      // Zero outside the read slot lets the link OR several read buses together
      rdata <= rd ? rd_d : {`PISR_DW{1'b0}};
    end
  end

endmodule

`default_nettype wire

/* File: common/pisr_regs.vh */
// Register offsets, field positions, reset values and timing counts for the PHY status bank
`ifndef PISR_REGS_VH
`define PISR_REGS_VH

// Geometry
`define PISR_NPORTS          3
`define PISR_AW              4
`define PISR_DW              8

// Register offsets
`define PISR_OFS_LINKCTL     4'h5
`define PISR_OFS_PAGEPORT    4'h7
`define PISR_OFS_PSTAT0      4'h8
`define PISR_OFS_PSTAT1      4'h9

// Link and interrupt control register fields
`define PISR_BIT_LINK_ACTIVE_CONTROL       7
`define PISR_BIT_RESUME_EVENT_ENABLE        6
`define PISR_BIT_STATE_TIMEOUT_FLAG        5
`define PISR_BIT_PEI         4
`define PISR_BIT_FASTARB     3
`define PISR_BIT_MIXSPD      2
`define PISR_RST_LINK_ACTIVE_CONTROL       1'b1

// Page and port selection fields
`define PISR_PAGE_HI         7
`define PISR_PAGE_LO         5
`define PISR_PORT_HI         3
`define PISR_PORT_LO         0
`define PISR_PAGE_STATUS     3'h0

// Port status page, first register
`define PISR_LA_HI           7
`define PISR_LA_LO           6
`define PISR_LB_HI           5
`define PISR_LB_LO           4
`define PISR_BIT_CH          3
`define PISR_BIT_CON         2
`define PISR_BIT_BIAS        1
`define PISR_BIT_DIS         0

// Port status page, second register
`define PISR_SPD_HI          7
`define PISR_SPD_LO          5
`define PISR_BIT_PIE         4
`define PISR_BIT_FAULT       3

// Connection debounce time
`define PISR_CLK_HZ          10000000
`define PISR_DEBOUNCE_MS     341
// 341 ms of 10 MHz cycles, sized to the counter so nothing is cut on use
`define PISR_DEBOUNCE_CYC    22'h340850
`define PISR_DBW             22

`endif

/* File: bench/pisr_chk.sv */
// Port-level assertions for the PHY status bank
`default_nettype none
module pisr_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       ce,
  // Register port
  input wire logic [3:0] addr,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // Events and link
  input wire logic       state_timeout,
  input wire logic       bus_reset_req,
  input wire logic       link_power_status,
  input wire logic       link_wake_output,
  input wire logic       fast_arbitration_enable,
  input wire logic       mixed_speed_concat_enable,
  input wire logic [2:0] port_disabled
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  sequence s_tmo;
    ce && state_timeout;
  endsequence
  // Reserved and foreign offsets read zero, never stale data
  sequence s_dead_rd;
    ce && rd && !(addr inside {4'h5, 4'h7, 4'h8, 4'h9});
  endsequence
  chk_tmo_bus_reset: assert property (s_tmo |=> bus_reset_req)
    else $error("no bus reset request after timeout");
  chk_reset_pulse: assert property (ce && bus_reset_req && !state_timeout |=> !bus_reset_req)
    else $error("bus reset request too long");
  chk_reset_cause: assert property ($rose(bus_reset_req) |-> $past(state_timeout))
    else $error("bus reset request without timeout");
  chk_dead_zero: assert property (s_dead_rd |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rd_idle: assert property ((ce && !rd) [*2] |-> rdata == 8'h00)
    else $error("read data outside read slot");
  chk_wake_cause: assert property ($rose(link_wake_output) |->
    $past(state_timeout) || $past(wr) || $changed(link_power_status))
    else $error("link wake without cause");
  chk_enable_src: assert property ($changed({fast_arbitration_enable,
    mixed_speed_concat_enable}) |-> $past(wr) && $past(addr) == 4'h5)
    else $error("enables changed without write");
  chk_dis_src: assert property ($changed(port_disabled) |->
    $past(wr) && $past(addr) == 4'h8)
    else $error("port disable changed without write");
endmodule
`default_nettype wire

/* File: bench/pisr_lnk_model.sv */
// Link controller model: register bus master and link power
`default_nettype none
module pisr_lnk_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output var  logic [3:0] addr,
  output var  logic [7:0] wdata,
  output var  logic       wr,
  output var  logic       rd,
  // Link power
  output var  logic       link_power_status
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] exp_q[$];
  initial {addr, wdata, wr, rd, link_power_status} = 15'h0001;
  ////////////////////////////////////////////////////////////
  // register writes
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Expected data is noted before the strobe goes out
  task automatic bus_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic arb_cfg(input logic [7:0] ctl, input logic enh);
    bus_wr(4'h5, enh ? ctl : ctl & 8'hf7);
  endtask
  task automatic set_lps(input logic v);
    @(posedge clk);
    link_power_status <= v;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the PHY status bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DB = 8;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce = 1'b1;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic       wr, rd, rd_q, state_timeout, bus_reset_req, link_power_status;
  logic       link_wake_output, fast_arbitration_enable, mixed_speed_concat_enable;
  logic [5:0] line_a_state, line_b_state;
  logic [2:0] port_child, port_suspended, conn_raw, bias_debounced, resume_start, fault_event;
  logic [2:0] port_disabled;
  logic [8:0] peer_speed;
  int         num_errors = 0, checks = 0, seed = 32'h8f26, p;
  always #50 clk = ~clk;
  pisr_core #(.DEBOUNCE_CYC(22'(DB))) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .state_timeout(state_timeout), .bus_reset_req(bus_reset_req),
    .link_power_status(link_power_status), .link_wake_output(link_wake_output),
    .fast_arbitration_enable(fast_arbitration_enable),
    .mixed_speed_concat_enable(mixed_speed_concat_enable),
    .line_a_state(line_a_state), .line_b_state(line_b_state), .port_child(port_child),
    .port_suspended(port_suspended), .conn_raw(conn_raw), .bias_debounced(bias_debounced),
    .peer_speed(peer_speed), .resume_start(resume_start), .fault_event(fault_event),
    .port_disabled(port_disabled));
  pisr_lnk_model i_lnk (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .link_power_status(link_power_status));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Child reads set for a child port, or unless the port is connected, enabled and awake
  function automatic logic [7:0] stat0(input int q, input logic con, input logic dis);
    logic ch;
    ch = !con || dis || port_suspended[q] || port_child[q];
    return {line_a_state[2*q+:2], line_b_state[2*q+:2], ch, con, bias_debounced[q], dis};
  endfunction
  task automatic test_done;
    chk("pending_reads", 8'(i_lnk.exp_q.size()), 8'h00);
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    if (rd_q === 1'b1 && i_lnk.exp_q.size() == 0) chk("read_note", 8'h00, 8'h01);
    else if (rd_q === 1'b1) chk("rdata", rdata, i_lnk.exp_q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done;
  end
  initial begin
    {state_timeout, resume_start, fault_event, conn_raw, port_suspended} = '0;
    {port_child, bias_debounced, peer_speed} = 15'($random(seed));
    {line_a_state, line_b_state} = 12'h000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    i_lnk.bus_rd(4'h5, 8'h80);
    i_lnk.bus_rd(4'h7, 8'h00);
    i_lnk.bus_rd(4'h3, 8'h00);
    i_lnk.bus_rd(4'ha, 8'h00);
    i_lnk.bus_wr(4'h7, 8'h20);
    i_lnk.bus_rd(4'h7, 8'h20);
    i_lnk.bus_rd(4'h8, 8'h00);
    for (p = 0; p < 4; p++) begin
      line_a_state <= {3{2'(p)}};
      line_b_state <= {3{~2'(p)}};
      i_lnk.bus_wr(4'h7, 8'(p));
      i_lnk.bus_rd(4'h8, p < 3 ? stat0(p, 1'b0, 1'b0) : 8'h00);
      i_lnk.bus_rd(4'h9, p < 3 ? {peer_speed[3*p+:3], 5'h00} : 8'h00);
    end
    i_lnk.bus_wr(4'h7, 8'h01);
    i_lnk.bus_wr(4'h9, 8'h10);
    @(posedge clk);
    {conn_raw, port_child} <= 6'b111000;
    @(negedge clk);
    i_lnk.bus_rd(4'h8, stat0(1, 1'b0, 1'b0));
    repeat (DB + 4) @(posedge clk);
    i_lnk.bus_rd(4'h8, stat0(1, 1'b1, 1'b0));
    i_lnk.bus_rd(4'h5, 8'h90);
    i_lnk.bus_wr(4'h5, 8'h80);
    i_lnk.bus_rd(4'h5, 8'h90);
    i_lnk.bus_wr(4'h5, 8'h90);
    i_lnk.bus_rd(4'h5, 8'h80);
    fault_event <= 3'b010;
    @(posedge clk);
    fault_event <= 3'b000;
    i_lnk.bus_rd(4'h9, {peer_speed[5:3], 5'h18});
    i_lnk.bus_wr(4'h9, 8'h18);
    i_lnk.bus_rd(4'h9, {peer_speed[5:3], 5'h10});
    i_lnk.bus_wr(4'h5, 8'h90);
    i_lnk.bus_rd(4'h5, 8'h80);
    i_lnk.bus_wr(4'h7, 8'h00);
    i_lnk.bus_wr(4'h8, 8'h01);
    @(negedge clk) chk("port_disabled", port_disabled, 8'h01);
    i_lnk.bus_wr(4'h8, 8'h00);
    state_timeout <= 1'b1;
    @(posedge clk);
    state_timeout <= 1'b0;
    @(negedge clk) chk("bus_reset_req", bus_reset_req, 8'h01);
    chk("link_wake_output", link_wake_output, 8'h00);
    i_lnk.bus_rd(4'h5, 8'ha0);
    fork
      i_lnk.bus_wr(4'h5, 8'ha0);
      begin
        @(posedge clk) state_timeout <= 1'b1;
        @(posedge clk) state_timeout <= 1'b0;
      end
    join
    i_lnk.bus_rd(4'h5, 8'ha0);
    i_lnk.bus_wr(4'h5, 8'hc0);
    @(negedge clk) chk("link_wake_output", link_wake_output, 8'h00);
    i_lnk.set_lps(1'b0);
    @(negedge clk) chk("link_wake_output", link_wake_output, 8'h01);
    i_lnk.set_lps(1'b1);
    i_lnk.bus_wr(4'h5, 8'h40);
    @(negedge clk) chk("link_wake_output", link_wake_output, 8'h01);
    i_lnk.bus_wr(4'h5, 8'he0);
    @(negedge clk) chk("link_wake_output", link_wake_output, 8'h00);
    @(posedge clk);
    resume_start <= 3'b100;
    @(posedge clk);
    resume_start <= 3'b000;
    i_lnk.bus_rd(4'h5, 8'hd0);
    i_lnk.arb_cfg(8'h9c, 1'b1);
    @(negedge clk) chk("enables", {fast_arbitration_enable, mixed_speed_concat_enable}, 8'h03);
    i_lnk.bus_rd(4'h5, 8'h8c);
    i_lnk.arb_cfg(8'h8c, 1'b0);
    @(negedge clk) chk("enables", {fast_arbitration_enable, mixed_speed_concat_enable}, 8'h01);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    i_lnk.bus_rd(4'h5, 8'h80);
    @(negedge clk) chk("enables", {fast_arbitration_enable, mixed_speed_concat_enable}, 8'h00);
    repeat (3) @(posedge clk);
    test_done;
  end
endmodule
bind pisr_core pisr_chk i_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wr(wr),
  .rd(rd), .rdata(rdata), .state_timeout(state_timeout), .bus_reset_req(bus_reset_req),
  .link_power_status(link_power_status), .link_wake_output(link_wake_output),
  .fast_arbitration_enable(fast_arbitration_enable),
  .mixed_speed_concat_enable(mixed_speed_concat_enable), .port_disabled(port_disabled));
`default_nettype wire
